//--- hw/brerr_map.svh
// Constants for the bridge error reporting block
`ifndef BRERR_MAP_SVH
`define BRERR_MAP_SVH
// ************************************************************
// Event bit positions
// ************************************************************
`define BRERR_EV_PWR_TABORT 0
`define BRERR_EV_PWR_MABORT 1
`define BRERR_EV_PWR_RETRY 2
`define BRERR_EV_PWR_PARITY 3
`define BRERR_EV_DWR_RETRY 4
`define BRERR_EV_DRD_RETRY 5
`define BRERR_EV_MTIMEOUT 6
`define BRERR_EV_FWD 7
`define BRERR_NUM_EV 8
`define BRERR_EV_RESET 8'h00
`define BRERR_RETRY_LIMIT 32'h0100_0000
`endif

//--- hw/brerr_pkg.sv
// Types for the bridge error reporting block
package brerr_pkg;
  // One bus transaction observation
  typedef struct packed {
    logic valid;      // Observation present this cycle
    logic is_read;    // Read (else write)
    logic is_posted;  // Posted write
    logic upstream;   // Direction upstream
    logic on_sec;     // Error seen on secondary bus
    logic own_target; // Bridge itself detected as target
  } brerr_obs_s;
  // Parity response configuration
  typedef struct packed {
    logic pri_perr_resp; // Primary command parity response
    logic sec_perr_resp; // Bridge control parity response
    logic serr_en;       // Primary command system error enable
    logic serr_fwd_en;   // Bridge control forward enable
    logic mto_serr_en;   // Bridge control master timeout enable
  } brerr_cfg_s;
  typedef enum logic [1:0] {LK_FREE, LK_HELD} brerr_lock_e;
endpackage

//--- hw/brerr_top.sv
// Parity and system error reporting for a transparent bridge
`timescale 1ns/1ps
`include "brerr_map.svh"
module brerr_top #(
  parameter int unsigned RETRY_LIMIT = `BRERR_RETRY_LIMIT
) (
  input wire logic i_clock,                     // 50 MHz clock
  input wire logic i_srst,                      // Sync reset, high
  input wire brerr_pkg::brerr_cfg_s i_cfg,      // Config bits
  input wire brerr_pkg::brerr_obs_s i_perr,     // Data parity error observation
  input wire logic i_pri_perr_seen,             // Primary parity error during dly write
  input wire logic i_secondary_system_err_n,    // Secondary system error pin
  input wire logic i_pwr_tabort,                // Posted write target abort
  input wire logic i_pwr_mabort,                // Posted write master abort
  input wire logic i_pwr_retry,                 // Posted write got target retry
  input wire logic i_pwr_done,                  // Posted write delivered
  input wire logic i_dwr_retry,                 // Delayed write got target retry
  input wire logic i_dwr_done,                  // Delayed write delivered
  input wire logic i_drd_retry,                 // Delayed read got target retry
  input wire logic i_drd_done,                  // Delayed read completed
  input wire logic i_mtimeout,                  // Delayed transaction master timeout
  input wire logic [7:0] i_ev_disable,          // Event disable register
  input wire logic [7:0] i_stat_clr,            // Write-one-clear for cause status
  input wire logic i_sig_serr_clr,              // Clear signaled flag
  input wire logic i_rcv_serr_clr,              // Clear received flag
  input wire logic i_pri_lock_req,              // Primary master locks
  input wire logic i_pri_lock_rel,              // Primary lock release
  input wire logic i_sec_lock_req,              // Secondary master locks
  input wire logic i_sec_lock_rel,              // Secondary lock release
  output logic o_secondary_parity_err_n,        // Secondary parity error out
  output logic o_primary_system_err_n,          // Primary system error out
  output logic o_sig_serr,                      // Signaled system error flag
  output logic o_rcv_serr,                      // Received system error flag
  output logic [7:0] o_serr_status,             // Cause status register
  output logic o_pwr_discard,                   // Posted write data discarded
  output logic o_dwr_discard,                   // Delayed write data discarded
  output logic o_drd_discard,                   // Delayed read abandoned
  output logic o_pri_locked,                    // Primary bus lock held
  output logic o_sec_locked                     // Secondary bus lock held
);
  // ************************************************************
  // Input synchroniser for the secondary system error pin
  // ************************************************************
  logic sserr_meta;
  logic sserr_sync;
  // Two flops before any reader
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sserr_meta <= 1'b1;
      sserr_sync <= 1'b1;
    end else begin
      sserr_meta <= i_secondary_system_err_n;
      sserr_sync <= sserr_meta;
    end
  end

  // ************************************************************
  // Secondary parity error decode
  // ************************************************************
  wire sec_tgt_wr = i_perr.valid & ~i_perr.is_read & i_perr.on_sec & i_perr.upstream;
  wire sec_init_rd = i_perr.valid & i_perr.is_read & i_perr.on_sec & ~i_perr.upstream;
  wire sec_own_err = (sec_tgt_wr | sec_init_rd) & i_cfg.sec_perr_resp;
  wire dly_up_pri = i_perr.valid & ~i_perr.is_read & ~i_perr.is_posted & i_perr.upstream
                    & ~i_perr.on_sec & i_pri_perr_seen;
  wire sec_reflect = dly_up_pri & i_cfg.pri_perr_resp & i_cfg.sec_perr_resp;
  wire next_sperr_n = ~(sec_own_err | sec_reflect);

  // ************************************************************
  // Parity-caused system error decode
  // ************************************************************
  wire pw = i_perr.valid & ~i_perr.is_read & i_perr.is_posted & ~i_perr.own_target;
  wire pw_down = pw & ~i_perr.upstream & i_perr.on_sec;
  wire pw_up = pw & i_perr.upstream & ~i_perr.on_sec;
  wire par_ev = (pw_down | pw_up) & i_cfg.pri_perr_resp & i_cfg.sec_perr_resp;

  // ************************************************************
  // Retry counters, one per queue
  // ************************************************************
  logic [31:0] rcnt [3];
  wire [2:0] r_try = {i_drd_retry, i_dwr_retry, i_pwr_retry};
  wire [2:0] r_done = {i_drd_done, i_dwr_done, i_pwr_done};
  logic [2:0] r_hit;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_retry
      assign r_hit[g] = r_try[g] & (rcnt[g] == RETRY_LIMIT - 1);
      // Count retries, restart on delivery or limit
      always_ff @(posedge i_clock) begin
        if (i_srst || r_done[g] || r_hit[g]) begin
          rcnt[g] <= 32'h0000_0000;
        end else if (r_try[g]) begin
          rcnt[g] <= rcnt[g] + 32'h0000_0001;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Event vector, masking and gating
  // ************************************************************
  logic [7:0] ev_raw;
  assign ev_raw[`BRERR_EV_PWR_TABORT] = i_pwr_tabort;
  assign ev_raw[`BRERR_EV_PWR_MABORT] = i_pwr_mabort;
  assign ev_raw[`BRERR_EV_PWR_RETRY] = r_hit[0];
  assign ev_raw[`BRERR_EV_PWR_PARITY] = par_ev;
  assign ev_raw[`BRERR_EV_DWR_RETRY] = r_hit[1];
  assign ev_raw[`BRERR_EV_DRD_RETRY] = r_hit[2];
  assign ev_raw[`BRERR_EV_MTIMEOUT] = i_mtimeout & i_cfg.mto_serr_en;
  assign ev_raw[`BRERR_EV_FWD] = ~sserr_sync & i_cfg.serr_fwd_en;
  // Timeout and forwarding are not maskable here
  wire [7:0] ev_mask = i_ev_disable & 8'h3f;
  wire [7:0] ev_live = ev_raw & ~ev_mask;
  wire fire = (|ev_live) & i_cfg.serr_en;
  wire [7:0] next_status = (o_serr_status & ~i_stat_clr) | (fire ? ev_live : 8'h00);
  wire next_sig = fire | (o_sig_serr & ~i_sig_serr_clr);
  wire next_rcv = ~sserr_sync | (o_rcv_serr & ~i_rcv_serr_clr);

  // ************************************************************
  // Output and status registers
  // ************************************************************
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_secondary_parity_err_n <= 1'b1;
      o_primary_system_err_n <= 1'b1;
      o_sig_serr <= 1'b0;
      o_rcv_serr <= 1'b0;
      o_serr_status <= `BRERR_EV_RESET;
      o_pwr_discard <= 1'b0;
      o_dwr_discard <= 1'b0;
      o_drd_discard <= 1'b0;
    end else begin
      o_secondary_parity_err_n <= next_sperr_n;
      o_primary_system_err_n <= ~fire;
      o_sig_serr <= next_sig;
      o_rcv_serr <= next_rcv;
      o_serr_status <= next_status;
      o_pwr_discard <= r_hit[0];
      o_dwr_discard <= r_hit[1];
      o_drd_discard <= r_hit[2];
    end
  end

  // ************************************************************
  // Independent lock trackers
  // ************************************************************
  brerr_pkg::brerr_lock_e plk;
  brerr_pkg::brerr_lock_e slk;
  // Each side moves on its own inputs only
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      plk <= brerr_pkg::LK_FREE;
      slk <= brerr_pkg::LK_FREE;
    end else begin
      case (plk)
        brerr_pkg::LK_FREE: if (i_pri_lock_req) plk <= brerr_pkg::LK_HELD;
        brerr_pkg::LK_HELD: if (i_pri_lock_rel) plk <= brerr_pkg::LK_FREE;
        default: plk <= brerr_pkg::LK_FREE;
      endcase
      case (slk)
        brerr_pkg::LK_FREE: if (i_sec_lock_req) slk <= brerr_pkg::LK_HELD;
        brerr_pkg::LK_HELD: if (i_sec_lock_rel) slk <= brerr_pkg::LK_FREE;
        default: slk <= brerr_pkg::LK_FREE;
      endcase
    end
  end
  // Next lock state per side, so the flag outputs come from their own flops
  wire next_pri_held = (plk == brerr_pkg::LK_HELD) ? ~i_pri_lock_rel : i_pri_lock_req;
  wire next_sec_held = (slk == brerr_pkg::LK_HELD) ? ~i_sec_lock_rel : i_sec_lock_req;
  // Lock flags registered alongside the trackers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pri_locked <= 1'b0;
      o_sec_locked <= 1'b0;
    end else begin
      o_pri_locked <= next_pri_held;
      o_sec_locked <= next_sec_held;
    end
  end
endmodule

//--- test/brerr_properties.sv
// Concurrent checks on the error reporting ports
`timescale 1ns/1ps
module brerr_properties #(
  parameter int unsigned RETRY_LIMIT = 4
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire brerr_pkg::brerr_cfg_s i_cfg,
  input wire brerr_pkg::brerr_obs_s i_perr,
  input wire logic i_pri_perr_seen,
  input wire logic i_secondary_system_err_n,
  input wire logic i_pwr_tabort,
  input wire logic i_mtimeout,
  input wire logic [7:0] i_ev_disable,
  input wire logic i_sig_serr_clr,
  input wire logic i_pri_lock_req,
  input wire logic i_pri_lock_rel,
  input wire logic i_sec_lock_req,
  input wire logic i_sec_lock_rel,
  input wire logic o_secondary_parity_err_n,
  input wire logic o_primary_system_err_n,
  input wire logic o_sig_serr,
  input wire logic o_rcv_serr,
  input wire logic [7:0] o_serr_status,
  input wire logic o_pri_locked,
  input wire logic o_sec_locked
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  // ********************
  // Sequences
  // ********************
  sequence s_fwd_low;
    (!i_secondary_system_err_n && i_cfg.serr_fwd_en && i_cfg.serr_en) [*3];
  endsequence
  sequence s_pw_parity;
    i_perr.valid && i_perr.is_posted && !i_perr.is_read && !i_perr.own_target
      && (i_perr.on_sec != i_perr.upstream);
  endsequence
  // ********************
  // Properties
  // ********************
  serr_needs_en_a: assert property (!o_primary_system_err_n |-> $past(i_cfg.serr_en))
    else $error("system error without enable");
  sig_flag_a: assert property (!o_primary_system_err_n |-> o_sig_serr)
    else $error("signaled flag missing");
  tabort_cause_a: assert property (i_pwr_tabort && i_cfg.serr_en && !i_ev_disable[0]
    |=> !o_primary_system_err_n && o_serr_status[0]) else $error("abort not reported");
  pw_parity_a: assert property (s_pw_parity ##0 (i_cfg.pri_perr_resp && i_cfg.sec_perr_resp
    && i_cfg.serr_en && !i_ev_disable[3]) |=> !o_primary_system_err_n) else $error("parity");
  fwd_serr_a: assert property (s_fwd_low |=> !o_primary_system_err_n)
    else $error("forward missing");
  rcv_flag_a: assert property (!i_secondary_system_err_n |-> ##3 o_rcv_serr)
    else $error("received flag missing");
  spe_gate_a: assert property (!o_secondary_parity_err_n
    |-> $past(i_perr.valid) && $past(i_cfg.sec_perr_resp)) else $error("parity out ungated");
  spe_read_a: assert property (i_perr.valid && i_perr.is_read && !i_perr.upstream
    && i_perr.on_sec && i_cfg.sec_perr_resp |=> !o_secondary_parity_err_n) else $error("read");
  spe_quiet_a: assert property (i_perr.valid && !i_perr.on_sec && !i_pri_perr_seen
    |=> o_secondary_parity_err_n) else $error("parity out on primary error");
  mto_cause_a: assert property (i_mtimeout && i_cfg.mto_serr_en && i_cfg.serr_en
    |=> o_serr_status[6]) else $error("timeout not reported");
  flag_hold_a: assert property (o_sig_serr && !i_sig_serr_clr |=> o_sig_serr)
    else $error("flag lost");
  lock_both_a: assert property (i_pri_lock_req && i_sec_lock_req
    && !i_pri_lock_rel && !i_sec_lock_rel
    |=> o_pri_locked && o_sec_locked) else $error("locks not independent");
endmodule
bind brerr_top brerr_properties #(.RETRY_LIMIT(RETRY_LIMIT)) u_brerr_properties (.*);

//--- test/brerr_sec_agent.sv
// Secondary bus agent that signals system errors
`timescale 1ns/1ps
module brerr_sec_agent (
  input wire logic i_clock,             // Bus clock
  input wire logic [3:0] i_len,         // Low cycles, loaded when nonzero
  output logic o_secondary_system_err_n // Pin with pull-up
);
  logic [3:0] cnt = 4'h0;
  // Count down the low time, pull-up level once released
  always_ff @(posedge i_clock) begin
    cnt <= (i_len != 4'h0) ? i_len : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
  end
  assign o_secondary_system_err_n = (cnt == 4'h0);
endmodule

//--- test/brerr_top_bench.sv
// Self-checking bench for the error reporting block
`timescale 1ns/1ps
module brerr_top_bench;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  brerr_pkg::brerr_cfg_s cfg = '0;
  brerr_pkg::brerr_obs_s perr = '0;
  logic seen = 1'b0, tab = 1'b0, mab = 1'b0, mto = 1'b0, sclr = 1'b0, rclr = 1'b0, got;
  logic [2:0] rt = 3'h0, dn = 3'h0, disc;
  logic [3:0] lk = 4'h0, len = 4'h0;
  logic [7:0] evd = 8'h00, stclr = 8'h00, st;
  logic spe_n, pse_n, sig, rcv, pin, plk, slk;
  logic [13:0] rows [13] = '{14'h32e1, 14'h32a3, 14'h34e3, 14'h2fe1, 14'h2ae2, 14'h2ce2,
    14'h2a63, 14'h2ac3, 14'h29e3, 14'h24e5, 14'h24a7, 14'h26e1, 14'h22e3};
  int n_errors = 0, n_tests = 0, cyc = 0;
  brerr_sec_agent u_brerr_sec_agent (.i_clock(i_clock), .i_len(len),
    .o_secondary_system_err_n(pin));
  brerr_top #(.RETRY_LIMIT(4)) u_brerr_top (
    .i_clock(i_clock), .i_srst(i_srst), .i_cfg(cfg), .i_perr(perr), .i_pri_perr_seen(seen),
    .i_secondary_system_err_n(pin), .i_pwr_tabort(tab), .i_pwr_mabort(mab),
    .i_pwr_retry(rt[0]), .i_pwr_done(dn[0]), .i_dwr_retry(rt[1]), .i_dwr_done(dn[1]),
    .i_drd_retry(rt[2]), .i_drd_done(dn[2]), .i_mtimeout(mto), .i_ev_disable(evd),
    .i_stat_clr(stclr), .i_sig_serr_clr(sclr), .i_rcv_serr_clr(rclr),
    .i_pri_lock_req(lk[0]), .i_pri_lock_rel(lk[1]), .i_sec_lock_req(lk[2]),
    .i_sec_lock_rel(lk[3]), .o_secondary_parity_err_n(spe_n), .o_primary_system_err_n(pse_n),
    .o_sig_serr(sig), .o_rcv_serr(rcv), .o_serr_status(st), .o_pwr_discard(disc[0]),
    .o_dwr_discard(disc[1]), .o_drd_discard(disc[2]), .o_pri_locked(plk), .o_sec_locked(slk));
  // Clock and hang limit
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 1000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask
  // Pin pulse from the agent, noting any system error output
  task automatic sec_pulse();
    got = 1'b0;
    len = 4'h3;
    tick();
    len = 4'h0;
    repeat (6) begin
      tick();
      got |= !pse_n;
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    #1 i_srst = 1'b0;
    chk({spe_n, pse_n, sig, rcv, st, plk, slk}, 14'h3000);
    foreach (rows[i]) begin
      {perr, cfg, seen} = rows[i][13:2];
      tick();
      chk({spe_n, pse_n}, rows[i][1:0]);
      perr = '0;
      seen = 1'b0;
      tick();
    end
    cfg = 5'h04;
    chk(sig, 1'b1);
    sclr = 1'b1;
    stclr = 8'hff;
    tick();
    chk({sig, st}, 9'h000);
    {sclr, stclr, tab, mab} = 11'h003;
    tick();
    chk({pse_n, sig, st}, 10'h103);
    {evd, tab, mab} = 10'h006;
    tick();
    chk(pse_n, 1'b1);
    {evd, tab} = 9'h000;
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < 4; n++) begin
        rt = 3'h1 << k;
        tick();
        chk(disc, (n == 3) ? (3'h1 << k) : 3'h0);
      end
      rt = 3'h0;
      tick();
    end
    chk(st & 8'h34, 8'h34);
    {evd, mto} = 9'h1ff;
    tick();
    chk(pse_n, 1'b1);
    cfg = 5'h05;
    tick();
    chk({pse_n, st[6]}, 2'b01);
    {evd, mto, cfg} = 14'h0004;
    sec_pulse();
    chk({got, rcv, st[7]}, 3'b010);
    rclr = 1'b1;
    tick();
    chk(rcv, 1'b0);
    {rclr, cfg} = 6'h06;
    sec_pulse();
    chk({got, rcv, st[7]}, 3'b111);
    lk = 4'h5;
    tick();
    chk({plk, slk}, 2'b11);
    lk = 4'h2;
    tick();
    chk({plk, slk}, 2'b01);
    lk = 4'h0;
    finish_test();
  end
endmodule
